/* File: verilog/upsc_pkg.sv */
// Package for the USB / PS2 status and control register bank.
// Assumes one system clock and a plain address/strobe register port.
package upsc_pkg;
  localparam logic [7:0] UPSC_ADDR_STATUS = 8'h1a;
  localparam logic [7:0] UPSC_ADDR_EVENT = 8'h1b;
  localparam logic [7:0] UPSC_ADDR_CLOCK = 8'h1c;
  localparam logic [7:0] UPSC_ADDR_TABLE_READ_HIGH_PTR = 8'h1f;
  localparam int ST_SUSPEND = 0;
  localparam int ST_WAKE = 1;
  localparam int ST_BUS_RESET = 2;
  localparam int ST_RESUME = 3;
  localparam int ST_DATA_IN = 4;
  localparam int ST_CLOCK_IN = 5;
  localparam int ST_DATA_OUT = 6;
  localparam int ST_CLOCK_OUT = 7;
  localparam int EV_EP0 = 0;
  localparam int EV_EP1 = 1;
  localparam int EV_LEGACY = 4;
  localparam int EV_SERIAL = 5;
  localparam int EV_USB_FLAG = 7;
  localparam int CK_ENABLE = 3;
  localparam int CK_DEEP = 4;
  localparam int CK_LEGACY_FLAG = 7;
  localparam logic [7:0] EV_WRITE_MASK = 8'hb3;
  localparam logic [7:0] CK_RESET = 8'h00;
  localparam logic [1:0] KB_OUT_RESET = 2'h3;
  localparam int CLK_HZ = 20000000;
  localparam int IDLE_MS = 3;
  localparam int IDLE_CYCLES = CLK_HZ / 1000 * IDLE_MS;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } upsc_bus_t;
  typedef struct packed {
    logic oe;
    logic out;
  } upsc_pin_t;
endpackage : upsc_pkg

/* File: verilog/upsc_idle_timer.sv */
// Bus idle timer: flags suspend after the idle limit with no bus activity.
// Assumes activity is a synchronous level from the USB engine.
`timescale 1ns/1ps
`default_nettype none
module upsc_idle_timer #(
  parameter int LIMIT = 60000
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic activity_in,
  output logic idle_out
);
  logic [31:0] cnt_q, cnt_d;
  logic idle_q, idle_d;
  always_comb begin
    cnt_d = cnt_q;
    idle_d = idle_q;
    if (activity_in) begin
      cnt_d = 32'h0;
      idle_d = 1'b0;
    end else if (cnt_q < 32'(LIMIT)) begin
      cnt_d = cnt_q + 32'h1;
    end else begin
      idle_d = 1'b1;
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 32'h0;
      idle_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      idle_q <= idle_d;
    end
  end
  assign idle_out = idle_q;
endmodule : upsc_idle_timer
`default_nettype wire

/* File: verilog/upsc_regs.sv */
// USB / PS2 status and control register bank with line steering.
// Assumes synchronous inputs and a master that never waits.
// Behaviour
// - Suspend status reads at status bit 0.
// - Write-only remote wake at status bit 1.
// - Bus reset flag at status bit 2.
// - Resume event sets status bit 3.
// - Pin outputs from bits 6,7, reset one.
// - Endpoint access sets flag; interrupt if enabled, stack not full.
// - Endpoint flags bits 0,1; block while set.
// - Event bit 4 selects legacy PS2 mode.
// - Event bit 5 selects USB mode.
// - Selectors route lines to PS2 or USB.
// - USB mode flag at event bit 7.
// - Clock bit 3 enables the bus clock.
// - Clock bit 4 deep suspend, blocked in USB.
// - PS2 mode flag at clock bit 7.
// - Table high pointer returns fetched bits 10:8.
// - Idle over 3 ms enters suspend, interrupts.
`timescale 1ns/1ps
`default_nettype none
module upsc_regs #(
  parameter int IDLE_LIMIT = upsc_pkg::IDLE_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire upsc_pkg::upsc_bus_t bus_in,
  output logic [7:0] rdata_out,
  input wire logic bus_activity_in,
  input wire logic bus_reset_in,
  input wire logic resume_in,
  input wire logic [1:0] ep_access_in,
  input wire logic usb_int_enable_in,
  input wire logic stack_full_in,
  input wire logic table_read_in,
  input wire logic [10:0] table_word_in,
  input wire logic minus_line_in,
  input wire logic plus_line_in,
  input wire upsc_pkg::upsc_pin_t sie_minus_in,
  input wire upsc_pkg::upsc_pin_t sie_plus_in,
  output upsc_pkg::upsc_pin_t minus_line_out,
  output upsc_pkg::upsc_pin_t plus_line_out,
  output logic remote_wake_pulse_out,
  output logic usb_int_out,
  output logic bus_clock_enable_out,
  output logic deep_suspend_out
);
  import upsc_pkg::*;

  function automatic logic hit(input upsc_bus_t b, input logic [7:0] a);
    hit = b.wr && (b.addr == a);
  endfunction : hit

  logic idle;
  logic suspend_q, suspend_d;
  logic wake_q, wake_d;
  logic bus_reset_q, bus_reset_d;
  logic resume_q, resume_d;
  logic [1:0] kb_out_q, kb_out_d;
  logic [7:0] ev_q, ev_d;
  logic [7:0] ck_q, ck_d;
  logic [2:0] table_read_high_ptr_q, table_read_high_ptr_d;
  logic [7:0] rdata_q, rdata_d;
  logic int_q, int_d;
  logic [1:0] ep_set;
  logic legacy_mode, usb_mode;
  logic kb_data_in, kb_clock_in;

  upsc_idle_timer #(.LIMIT(IDLE_LIMIT)) u_idle (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .activity_in(bus_activity_in),
    .idle_out(idle)
  );

  assign legacy_mode = ev_q[EV_LEGACY] && !ev_q[EV_SERIAL];
  assign usb_mode = ev_q[EV_SERIAL] && !ev_q[EV_LEGACY];
  // Open-drain style: an output bit of 1 releases the line so it can be read.
  assign kb_data_in = minus_line_in & kb_out_q[0];
  assign kb_clock_in = plus_line_in & kb_out_q[1];

  always_comb begin
    minus_line_out = '0;
    plus_line_out = '0;
    if (usb_mode) begin
      minus_line_out = sie_minus_in;
      plus_line_out = sie_plus_in;
    end else if (legacy_mode) begin
      minus_line_out = '{oe: !kb_out_q[0], out: 1'b0};
      plus_line_out = '{oe: !kb_out_q[1], out: 1'b0};
    end
  end

  always_comb begin
    // An endpoint access is ignored while its flag is still set.
    ep_set = ep_access_in & ~ev_q[1:0];
    suspend_d = idle;
    wake_d = 1'b0;
    bus_reset_d = bus_reset_q;
    resume_d = resume_q;
    kb_out_d = kb_out_q;
    ev_d = ev_q;
    ck_d = ck_q;
    table_read_high_ptr_d = table_read_high_ptr_q;
    if (hit(bus_in, UPSC_ADDR_STATUS)) begin
      wake_d = bus_in.wdata[ST_WAKE];
      bus_reset_d = bus_in.wdata[ST_BUS_RESET];
      kb_out_d = {bus_in.wdata[ST_CLOCK_OUT], bus_in.wdata[ST_DATA_OUT]};
    end
    if (hit(bus_in, UPSC_ADDR_EVENT)) begin
      ev_d = bus_in.wdata & EV_WRITE_MASK;
    end
    if (hit(bus_in, UPSC_ADDR_CLOCK)) begin
      ck_d = bus_in.wdata;
    end
    if (usb_mode) begin
      ck_d[CK_DEEP] = 1'b0;
    end
    if (bus_reset_in) begin
      bus_reset_d = 1'b1;
    end
    if (resume_in) begin
      resume_d = 1'b1;
    end else if (!suspend_q) begin
      resume_d = 1'b0;
    end
    ev_d[1:0] = ev_d[1:0] | ep_set;
    if (table_read_in) begin
      table_read_high_ptr_d = table_word_in[10:8];
    end
    int_d = (usb_int_enable_in && !stack_full_in && |ep_set)
      || (idle && !suspend_q) || (!idle && suspend_q) || resume_in;
    rdata_d = 8'h00;
    if (bus_in.rd) begin
      case (bus_in.addr)
        UPSC_ADDR_STATUS: rdata_d = {2'b00, kb_clock_in, kb_data_in, resume_q,
          bus_reset_q, 1'b0, suspend_q};
        UPSC_ADDR_EVENT: rdata_d = ev_q;
        UPSC_ADDR_CLOCK: rdata_d = ck_q;
        UPSC_ADDR_TABLE_READ_HIGH_PTR: rdata_d = {5'h00, table_read_high_ptr_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      suspend_q <= 1'b0;
      wake_q <= 1'b0;
      bus_reset_q <= 1'b0;
      resume_q <= 1'b0;
      kb_out_q <= KB_OUT_RESET;
      ev_q <= 8'h00;
      ck_q <= CK_RESET;
      table_read_high_ptr_q <= 3'h0;
      rdata_q <= 8'h00;
      int_q <= 1'b0;
    end else begin
      suspend_q <= suspend_d;
      wake_q <= wake_d;
      bus_reset_q <= bus_reset_d;
      resume_q <= resume_d;
      kb_out_q <= kb_out_d;
      ev_q <= ev_d;
      ck_q <= ck_d;
      table_read_high_ptr_q <= table_read_high_ptr_d;
      rdata_q <= rdata_d;
      int_q <= int_d;
    end
  end

  assign rdata_out = rdata_q;
  assign remote_wake_pulse_out = wake_q;
  assign usb_int_out = int_q;
  assign bus_clock_enable_out = ck_q[CK_ENABLE];
  assign deep_suspend_out = ck_q[CK_DEEP];

  a_ep_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ep_access_in[0] && !ev_q[0] |=> ev_q[0])
    else $error("endpoint flag not set");
  a_ep_int: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ep_access_in[0] && !ev_q[0] && usb_int_enable_in && !stack_full_in |=> usb_int_out)
    else $error("endpoint interrupt missing");
  a_reset_flag_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    bus_reset_in |=> bus_reset_q)
    else $error("bus reset flag lost");
  a_resume_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    resume_in |=> resume_q)
    else $error("resume not recorded");
  a_deep_blocked: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    usb_mode |=> !deep_suspend_out || !usb_mode)
    else $error("deep suspend set in usb mode");
  a_lines_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !ev_q[EV_LEGACY] && !ev_q[EV_SERIAL] |-> !minus_line_out.oe && !plus_line_out.oe)
    else $error("line driven with no selector");
  a_suspend_follows: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(idle) |=> suspend_q && usb_int_out)
    else $error("suspend not entered");
  a_table_read_high_ptr_load: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    table_read_in |=> table_read_high_ptr_q == $past(table_word_in[10:8]))
    else $error("table high bits wrong");
  a_read_status: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    bus_in.rd && bus_in.addr == UPSC_ADDR_STATUS |=> rdata_out[0] == $past(suspend_q))
    else $error("suspend bit misread");

  // Independent count of quiet bus cycles, kept so that the idle limit can be checked.
  logic [31:0] quiet_q, quiet_d;
  always_comb begin
    quiet_d = quiet_q;
    if (bus_activity_in) begin
      quiet_d = 32'h0;
    end else if (quiet_q <= 32'(IDLE_LIMIT)) begin
      quiet_d = quiet_q + 32'h1;
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quiet_q <= 32'h0;
    end else begin
      quiet_q <= quiet_d;
    end
  end
  a_idle_limit: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    idle == (quiet_q > 32'(IDLE_LIMIT)))
    else $error("idle limit not kept");

  // Leaving suspend takes one cycle to reach both the status bit and the interrupt.
  sequence s_link_wakes;
    $fell(idle);
  endsequence : s_link_wakes
  sequence s_exit_reported;
    !suspend_q && usb_int_out;
  endsequence : s_exit_reported
  a_suspend_exit: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_link_wakes |=> s_exit_reported)
    else $error("suspend exit not reported");

  // An endpoint flag, once set, stays until firmware writes the event register.
  sequence s_ep1_fresh;
    ep_access_in[1] && !ev_q[1];
  endsequence : s_ep1_fresh
  a_ep1_flag_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_ep1_fresh |=> ev_q[1])
    else $error("endpoint one flag not set");
  a_ep_flag_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ev_q[0] && !hit(bus_in, UPSC_ADDR_EVENT) |=> ev_q[0])
    else $error("endpoint flag dropped");
  a_ep_int_gated: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ep_access_in != 2'h0 && (!usb_int_enable_in || stack_full_in) && !resume_in
      && idle == suspend_q |=> !usb_int_out)
    else $error("endpoint interrupt not gated");

  // Register port: a write shows one cycle later, a read answers one cycle later.
  a_event_mask: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    hit(bus_in, UPSC_ADDR_EVENT) && ep_access_in == 2'h0
      |=> ev_q == ($past(bus_in.wdata) & EV_WRITE_MASK))
    else $error("event register write wrong");
  a_wake_pulse: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    hit(bus_in, UPSC_ADDR_STATUS) |=> remote_wake_pulse_out == $past(bus_in.wdata[ST_WAKE]))
    else $error("remote wake pulse wrong");
  a_wake_single: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !hit(bus_in, UPSC_ADDR_STATUS) |=> !remote_wake_pulse_out)
    else $error("remote wake pulse too long");
  a_reset_flag_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    hit(bus_in, UPSC_ADDR_STATUS) && !bus_reset_in |=> bus_reset_q == $past(bus_in.wdata[2]))
    else $error("bus reset flag write lost");
  a_resume_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    resume_q && suspend_q |=> resume_q)
    else $error("resume flag dropped in suspend");
  a_clock_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    hit(bus_in, UPSC_ADDR_CLOCK)
      |=> bus_clock_enable_out == $past(bus_in.wdata[CK_ENABLE])
      && ck_q[CK_LEGACY_FLAG] == $past(bus_in.wdata[CK_LEGACY_FLAG]))
    else $error("clock register write lost");
  a_deep_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    hit(bus_in, UPSC_ADDR_CLOCK) && usb_mode |=> !deep_suspend_out)
    else $error("deep suspend written in usb mode");
  a_table_read_high_ptr_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !table_read_in |=> $stable(table_read_high_ptr_q))
    else $error("table high bits changed");
  a_read_event: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    bus_in.rd && bus_in.addr == UPSC_ADDR_EVENT |=> rdata_out == $past(ev_q))
    else $error("event register misread");
  a_read_table_read_high_ptr: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    bus_in.rd && bus_in.addr == UPSC_ADDR_TABLE_READ_HIGH_PTR |=> rdata_out == {5'h00, $past(table_read_high_ptr_q)})
    else $error("table high pointer misread");
  a_read_flags: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    bus_in.rd && bus_in.addr == UPSC_ADDR_STATUS
      |=> rdata_out[3:1] == {$past(resume_q), $past(bus_reset_q), 1'b0})
    else $error("status flags misread");
  a_kb_read_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    bus_in.rd && bus_in.addr == UPSC_ADDR_STATUS |=> (rdata_out[5:4] & ~$past(kb_out_q)) == 2'h0)
    else $error("pin input read while driven low");

  // Line steering follows the selectors and the pin output bits.
  a_ps2_drive: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    legacy_mode && hit(bus_in, UPSC_ADDR_STATUS) |=> !legacy_mode
      || (minus_line_out.oe == !$past(bus_in.wdata[ST_DATA_OUT])
      && plus_line_out.oe == !$past(bus_in.wdata[ST_CLOCK_OUT])))
    else $error("legacy line drive wrong");
  a_usb_lines: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ev_q[EV_SERIAL] && !ev_q[EV_LEGACY] |-> minus_line_out == sie_minus_in && plus_line_out == sie_plus_in)
    else $error("usb lines not steered");
endmodule : upsc_regs
`default_nettype wire

/* File: verification/upsc_host_model.sv */
// Host side of the two bus lines, with a pull-up on each line.
// Assumes the bank hands over pin structs with an output enable.
`timescale 1ns/1ps
`default_nettype none
module upsc_host_model
  import upsc_pkg::*;
(
  input wire upsc_pkg::upsc_pin_t minus_pin_in,
  input wire upsc_pkg::upsc_pin_t plus_pin_in,
  input wire logic [1:0] host_low_in,
  output logic minus_level_out,
  output logic plus_level_out
);
  // A released line floats to the pull-up unless the host pulls it low.
  assign minus_level_out = minus_pin_in.oe ? minus_pin_in.out : !host_low_in[0];
  assign plus_level_out = plus_pin_in.oe ? plus_pin_in.out : !host_low_in[1];
endmodule : upsc_host_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the status and control register bank.
// Assumes the host model for the lines and a short idle limit.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import upsc_pkg::*;
  logic sys_clk_in, rst_n_in, bus_activity_in, bus_reset_in, resume_in, usb_int_enable_in;
  logic stack_full_in, table_read_in, minus_line_in, plus_line_in, remote_wake_pulse_out;
  logic usb_int_out, bus_clock_enable_out, deep_suspend_out;
  logic [1:0] ep_access_in, hlow;
  logic [7:0] rdata_out;
  logic [10:0] table_word_in;
  upsc_bus_t bus_in;
  upsc_pin_t sie_minus_in, sie_plus_in, minus_line_out, plus_line_out;
  int error_cnt = 0, n_tests = 0, ints = 0, i0;
  upsc_regs #(.IDLE_LIMIT(20)) uut (.sys_clk_in, .rst_n_in, .bus_in, .rdata_out,
    .bus_activity_in, .bus_reset_in, .resume_in, .ep_access_in, .usb_int_enable_in,
    .stack_full_in, .table_read_in, .table_word_in, .minus_line_in, .plus_line_in,
    .sie_minus_in, .sie_plus_in, .minus_line_out, .plus_line_out, .remote_wake_pulse_out,
    .usb_int_out, .bus_clock_enable_out, .deep_suspend_out);
  upsc_host_model host (.minus_pin_in(minus_line_out), .plus_pin_in(plus_line_out),
    .host_low_in(hlow), .minus_level_out(minus_line_in), .plus_level_out(plus_line_in));
  initial begin
    sys_clk_in = 0;
    forever #25 sys_clk_in = !sys_clk_in;
  end
  always @(posedge sys_clk_in) if (usb_int_out === 1'b1) ints++;
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in) bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in) bus_in <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in) bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in) bus_in <= '0;
    #1 chk($sformatf("reg %h", a), rdata_out, exp);
  endtask : rd
  task automatic ints_since(input logic [7:0] exp);
    repeat (4) @(posedge sys_clk_in);
    #1 chk("interrupts", 8'(ints - i0), exp);
    i0 = ints;
  endtask : ints_since
  task automatic t_reset_wake;
    rd(8'h1a, 8'h30);
    rd(8'h1b, 8'h00);
    rd(8'h1c, 8'h00);
    rd(8'h1f, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h1a, 8'h02);
    #1 chk("wake", 8'(remote_wake_pulse_out), 8'h01);
    @(posedge sys_clk_in) #1 chk("wake end", 8'(remote_wake_pulse_out), 8'h00);
    rd(8'h1a, 8'h00);
    wr(8'h1a, 8'hc0);
  endtask : t_reset_wake
  task automatic t_endpoint;
    i0 = ints;
    @(posedge sys_clk_in) ep_access_in <= 2'h1;
    @(posedge sys_clk_in) ep_access_in <= 2'h0;
    ints_since(8'h01);
    rd(8'h1b, 8'h01);
    @(posedge sys_clk_in) ep_access_in <= 2'h1;
    @(posedge sys_clk_in) ep_access_in <= 2'h0;
    ints_since(8'h00);
    wr(8'h1b, 8'h00);
    @(posedge sys_clk_in) {ep_access_in, stack_full_in} <= 3'h5;
    @(posedge sys_clk_in) {ep_access_in, stack_full_in} <= 3'h0;
    ints_since(8'h00);
    rd(8'h1b, 8'h02);
    wr(8'h1b, 8'h00);
    @(posedge sys_clk_in) {ep_access_in, usb_int_enable_in} <= 3'h2;
    @(posedge sys_clk_in) {ep_access_in, usb_int_enable_in} <= 3'h1;
    ints_since(8'h00);
    rd(8'h1b, 8'h01);
    wr(8'h1b, 8'h00);
  endtask : t_endpoint
  task automatic t_modes;
    wr(8'h1b, 8'hff);
    rd(8'h1b, 8'hb3);
    #1 chk("both sel", 8'({minus_line_out, plus_line_out}), 8'h00);
    wr(8'h1b, 8'h10);
    wr(8'h1a, 8'h80);
    #1 chk("ps2 pins", 8'({minus_line_out, plus_line_out}), 8'h08);
    rd(8'h1a, 8'h20);
    hlow <= 2'h2;
    rd(8'h1a, 8'h00);
    hlow <= 2'h0;
    wr(8'h1c, 8'hd8);
    rd(8'h1c, 8'hd8);
    chk("clk en", 8'({bus_clock_enable_out, deep_suspend_out}), 8'h03);
    wr(8'h1b, 8'h20);
    rd(8'h1c, 8'hc8);
    chk("deep off", 8'(deep_suspend_out), 8'h00);
    wr(8'h1c, 8'hd8);
    rd(8'h1c, 8'hc8);
    #1 chk("usb pins", 8'({minus_line_out, plus_line_out}), 8'h0e);
    wr(8'h1a, 8'hc0);
  endtask : t_modes
  task automatic t_suspend_table;
    i0 = ints;
    @(posedge sys_clk_in) bus_activity_in <= 1'b0;
    repeat (30) @(posedge sys_clk_in);
    ints_since(8'h01);
    rd(8'h1a, 8'h11);
    @(posedge sys_clk_in) {resume_in, bus_reset_in} <= 2'h3;
    @(posedge sys_clk_in) {resume_in, bus_reset_in} <= 2'h0;
    rd(8'h1a, 8'h1d);
    wr(8'h1a, 8'hc0);
    rd(8'h1a, 8'h19);
    @(posedge sys_clk_in) bus_activity_in <= 1'b1;
    ints_since(8'h02);
    rd(8'h1a, 8'h10);
    @(posedge sys_clk_in) {table_read_in, table_word_in} <= 12'hdad;
    @(posedge sys_clk_in) table_read_in <= 1'b0;
    wr(8'h1f, 8'hff);
    rd(8'h1f, 8'h05);
  endtask : t_suspend_table
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    {rst_n_in, bus_reset_in, resume_in, ep_access_in, stack_full_in, table_read_in} = '0;
    {bus_activity_in, usb_int_enable_in, table_word_in, hlow, bus_in} = '0;
    bus_activity_in = 1'b1;
    usb_int_enable_in = 1'b1;
    sie_minus_in = '{oe: 1'b1, out: 1'b1};
    sie_plus_in = '{oe: 1'b1, out: 1'b0};
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset_wake;
    t_endpoint;
    t_modes;
    t_suspend_table;
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
